/* File: fic_cpu_model.sv */
// Purpose: CPU side model issuing register port cycles
// Assumes: requests change right after a rising edge
// Notes:   commands wait out the busy period before returning
module fic_cpu_model (
  // Clock
  input  wire logic            clk_i,
  // Design outputs
  input  wire logic [7:0]      rd_data_i,
  input  wire logic            stall_i,
  // Register port
  output fic_pkg::fic_bus_req_t bus_o
);
  initial bus_o = '0;
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus_o <= '0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    bus_o <= '0;
    #1;
    d = rd_data_i;
  endtask
  // Write then hold off while the core is stalled
  task automatic cmd(input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wr(a, d);
    repeat (2) @(posedge clk_i);
    #1;
    while (stall_i !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // Busy that never ends counts as a mismatch
    if (n == 1000) testbench.error_cnt++;
  endtask
endmodule

/* File: fic_iap_ctrl.sv */
// Purpose: in-application flash erase, program and read controller
// Assumes: CPU reaches registers over the plain 8-bit register port
// Notes:   VARIANT 0 block erase, 1 page of 32 words, 2 page of 64 words
// What this block does
// - Block variant erase clears 256 words picked by address bits 11..8.
// - Block variant write programs four words, low two address bits ignored.
// - Block variant gives 1024 four-word write units over the whole memory.
// - Page variants erase and write one page equal to buffer size.
// - Page erase selects page by upper bits, lower offset bits ignored.
// - A read returns exactly one 16-bit word from the addressed location.
// - Data registers accept writes while enabled flag or enable trigger high; buffer only while enabled flag high.
// - Program start bit stays high until the erase or write wait ends, hardware clears it then, before any automatic buffer clear.
// - Read needs read allow; read start cleared by hardware after fetch.
// - Buffer maps to addressed page; high byte write loads the word.
// - Each buffer load below the last word of the page increments the address, new value readable.
// - Address increment stops at the last word of the page.
// - Buffer clear bit starts a clear, hardware drops it when done.
// - Page variants clear the buffer automatically after every programming operation.
// - Software may clear the enabled flag; writing one does nothing.
// - Mode codes: 000 write, 001 erase, 011 read, 110 enable.
// - Erase and write act only after enable mode succeeded.
// - Enable trigger starts a timer, hardware clears trigger at expiry.
// - Writing 55h to the chip reset pattern register resets the chip.
// - CPU is stalled while a read, write or erase runs.
// - Writing data word 0 low byte loads nothing into the buffer.
//
// Design decisions made here: the plain strobed port and the register addresses.
module fic_iap_ctrl #(
  parameter int          VARIANT   = 2,
  parameter int unsigned ERASE_CYC = fic_pkg::ERASE_CYC_DEF,
  parameter int unsigned PROG_CYC  = fic_pkg::PROG_CYC_DEF,
  parameter logic [15:0] UNLOCK_1  = 16'h1111, // Arbitrary value
  parameter logic [15:0] UNLOCK_2  = 16'h2222, // Arbitrary value
  parameter logic [15:0] UNLOCK_3  = 16'h3333  // Arbitrary value
) (
  // Clock, reset and enable
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  // Register port
  input  wire fic_pkg::fic_bus_req_t bus_i,
  output logic      [7:0]           rd_data_o,
  // System signals
  output logic                      cpu_stall_o,
  output logic                      chip_reset_o
);

  localparam int ADDR_W  = 12 + VARIANT;
  localparam int HI_W    = ADDR_W - 8;
  localparam int ERASE_W = (VARIANT == 0) ? 8 : 4 + VARIANT;
  localparam int BUF_W   = (VARIANT == 0) ? 2 : ERASE_W;
  localparam bit PAGED   = (VARIANT != 0);
  localparam logic [7:0]  ERASE_LAST = 8'((1 << ERASE_W) - 1);
  localparam logic [7:0]  BUF_LAST   = 8'((1 << BUF_W) - 1);
  localparam logic [31:0] ERASE_LOAD = (ERASE_CYC > 0) ? 32'(ERASE_CYC) : 32'h1;
  localparam logic [31:0] PROG_LOAD  = (PROG_CYC > 0) ? 32'(PROG_CYC) : 32'h1;
  localparam logic [31:0] EN_LOAD    = 32'(fic_pkg::ENABLE_CYC);

  // Register state
  logic            flag;
  logic [2:0]      mode;
  logic            trig;
  logic            pstart;
  logic            rallow;
  logic            rstart;
  logic            bclr;
  logic [7:0]      rst_pat;
  logic [7:0]      addr_lo;
  logic [HI_W-1:0] addr_hi;
  logic [7:0]      dlo [4];
  logic [7:0]      dhi [4];

  // Sequencer state
  fic_pkg::fic_state_t state;
  logic [7:0]          idx;
  logic                phase;
  logic                clr_auto;
  logic                after_prog;
  logic [31:0]         wait_cnt;
  logic [31:0]         en_cnt;

  // Memory ports
  logic              fl_we;
  logic [ADDR_W-1:0] fl_addr;
  logic [15:0]       fl_wdata;
  logic [15:0]       fl_rdata;
  logic              bf_we;
  logic [BUF_W-1:0]  bf_addr;
  logic [15:0]       bf_wdata;
  logic [15:0]       bf_rdata;

  // Decoded events
  logic              idle;
  logic              wr;
  logic              ctrl_wr;
  logic              d0h_wr;
  logic              go_prog;
  logic              go_erase;
  logic              go_read;
  logic              go_clear;
  logic              reject_prog;
  logic              reject_read;
  logic              reject_clr;
  logic              wait_end;
  logic              read_done;
  logic              clr_last;
  logic              en_timeout;
  logic              unlock_ok;
  logic [ADDR_W-1:0] addr_full;
  logic [7:0]        rd_mux;

  // Register port decode, writes refused while the CPU is stalled
  assign idle      = (state == fic_pkg::FIC_ST_IDLE);
  assign wr        = ce_i && bus_i.wr && idle;
  assign ctrl_wr   = wr && (bus_i.addr == fic_pkg::REG_CTRL);
  assign d0h_wr    = wr && flag && (bus_i.addr == 4'(fic_pkg::REG_DATA0_L + 4'h1));
  assign addr_full = {addr_hi, addr_lo};

  // Command dispatch from the idle state
  assign go_prog     = idle && pstart && flag && (mode == fic_pkg::MODE_WRITE);
  assign go_erase    = idle && pstart && flag && (mode == fic_pkg::MODE_ERASE);
  assign reject_prog = idle && pstart && !go_prog && !go_erase;
  assign go_read     = idle && !pstart && rstart && rallow
                       && (mode == fic_pkg::MODE_READ);
  assign reject_read = idle && !pstart && rstart && !go_read;
  assign go_clear    = idle && !pstart && !rstart && bclr && PAGED;
  assign reject_clr  = idle && !pstart && !rstart && bclr && !PAGED;
  assign wait_end    = (state == fic_pkg::FIC_ST_WAIT) && (wait_cnt == 32'h1);
  assign read_done   = (state == fic_pkg::FIC_ST_READ) && phase;
  assign clr_last    = (state == fic_pkg::FIC_ST_CLEAR) && (idx == BUF_LAST);
  assign en_timeout  = trig && (en_cnt == 32'h1);
  assign unlock_ok   = (mode == fic_pkg::MODE_ENABLE)
                       && ({dhi[1], dlo[1]} == UNLOCK_1)
                       && ({dhi[2], dlo[2]} == UNLOCK_2)
                       && ({dhi[3], dlo[3]} == UNLOCK_3);

  // Control register, hardware clears first so a software set wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag   <= 1'b0;
      mode   <= 3'h0;
      trig   <= 1'b0;
      pstart <= 1'b0;
      rallow <= 1'b0;
      rstart <= 1'b0;
    end else if (ce_i) begin
      if (wait_end && !clr_auto || reject_prog) begin
        pstart <= 1'b0;
      end
      if (read_done || reject_read) begin
        rstart <= 1'b0;
      end
      if (en_timeout) begin
        trig <= 1'b0;
      end
      if (ctrl_wr) begin
        mode   <= bus_i.wdata[fic_pkg::CTRL_MODE_LSB +: 3];
        rallow <= bus_i.wdata[fic_pkg::CTRL_RALLOW];
        if (!bus_i.wdata[fic_pkg::CTRL_FLAG_BIT]) begin
          flag <= 1'b0;
        end
        if (bus_i.wdata[fic_pkg::CTRL_TRIG_BIT]) begin
          trig <= 1'b1;
        end
        if (bus_i.wdata[fic_pkg::CTRL_PSTART]) begin
          pstart <= 1'b1;
        end
        if (bus_i.wdata[fic_pkg::CTRL_RSTART]) begin
          rstart <= 1'b1;
        end
      end
      if (en_timeout && unlock_ok) begin
        flag <= 1'b1;
      end
    end
  end

  // Enable procedure timer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      en_cnt <= 32'h0;
    end else if (ce_i) begin
      if (ctrl_wr && bus_i.wdata[fic_pkg::CTRL_TRIG_BIT] && (!trig || en_timeout)) begin
        en_cnt <= EN_LOAD;
      end else if (trig && en_cnt != 32'h0) begin
        en_cnt <= en_cnt - 32'h1;
      end
    end
  end

  // Buffer clear control and chip reset pattern
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bclr    <= 1'b0;
      rst_pat <= fic_pkg::REG_RST;
    end else if (ce_i) begin
      if ((clr_last && !clr_auto) || reject_clr) begin
        bclr <= 1'b0;
      end
      if (wr && bus_i.addr == fic_pkg::REG_BUFCLR && bus_i.wdata[fic_pkg::BUFCLR_BIT]) begin
        bclr <= 1'b1;
      end
      if (wr && bus_i.addr == fic_pkg::REG_CHIPRST) begin
        rst_pat <= bus_i.wdata;
      end
    end
  end

  // Chip reset pulse on the reset pattern
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      chip_reset_o <= 1'b0;
    end else if (ce_i) begin
      chip_reset_o <= wr && (bus_i.addr == fic_pkg::REG_CHIPRST)
                      && (bus_i.wdata == fic_pkg::CHIP_RST_CODE);
    end
  end

  // Address pair, software load or auto increment on buffer fill
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_lo <= 8'h00;
      addr_hi <= '0;
    end else if (ce_i) begin
      if (wr && bus_i.addr == fic_pkg::REG_ADDR_L) begin
        addr_lo <= bus_i.wdata;
      end else if (wr && bus_i.addr == fic_pkg::REG_ADDR_H) begin
        addr_hi <= bus_i.wdata[HI_W-1:0];
      end else if (PAGED && d0h_wr && addr_lo[BUF_W-1:0] != BUF_LAST[BUF_W-1:0]) begin
        {addr_hi, addr_lo} <= addr_full + ADDR_W'(1);
      end
    end
  end

  // Data registers, open when enabled or unlocking; reads land in word 0
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 4; i++) begin
        dlo[i] <= fic_pkg::REG_RST;
        dhi[i] <= fic_pkg::REG_RST;
      end
    end else if (ce_i) begin
      if (read_done) begin
        {dhi[0], dlo[0]} <= fl_rdata;
      end else if (wr && (flag || trig) && bus_i.addr >= fic_pkg::REG_DATA0_L
                   && bus_i.addr <= fic_pkg::REG_DATA3_H) begin
        if (bus_i.addr[0]) begin
          dlo[2'((bus_i.addr - fic_pkg::REG_DATA0_L) >> 1)] <= bus_i.wdata;
        end else begin
          dhi[2'((bus_i.addr - fic_pkg::REG_DATA0_L) >> 1)] <= bus_i.wdata;
        end
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state      <= fic_pkg::FIC_ST_IDLE;
      idx        <= 8'h00;
      phase      <= 1'b0;
      clr_auto   <= 1'b0;
      after_prog <= 1'b0;
      wait_cnt   <= 32'h0;
    end else if (ce_i) begin
      case (state)
        fic_pkg::FIC_ST_IDLE: begin
          idx   <= 8'h00;
          phase <= 1'b0;
          if (go_prog) begin
            state <= fic_pkg::FIC_ST_PROG;
          end else if (go_erase) begin
            state <= fic_pkg::FIC_ST_ERASE;
          end else if (go_read) begin
            state <= fic_pkg::FIC_ST_READ;
          end else if (go_clear) begin
            clr_auto <= 1'b0;
            state    <= fic_pkg::FIC_ST_CLEAR;
          end
        end
        fic_pkg::FIC_ST_ERASE: begin
          idx <= idx + 8'h01;
          if (idx == ERASE_LAST) begin
            after_prog <= 1'b0;
            wait_cnt   <= ERASE_LOAD;
            state      <= fic_pkg::FIC_ST_WAIT;
          end
        end
        fic_pkg::FIC_ST_PROG: begin
          phase <= !phase;
          if (phase) begin
            idx <= idx + 8'h01;
            if (idx == BUF_LAST) begin
              after_prog <= 1'b1;
              wait_cnt   <= PROG_LOAD;
              state      <= fic_pkg::FIC_ST_WAIT;
            end
          end
        end
        fic_pkg::FIC_ST_READ: begin
          phase <= 1'b1;
          if (phase) begin
            state <= fic_pkg::FIC_ST_IDLE;
          end
        end
        fic_pkg::FIC_ST_WAIT: begin
          wait_cnt <= wait_cnt - 32'h1;
          idx      <= 8'h00;
          if (wait_end) begin
            if (after_prog && PAGED) begin
              clr_auto <= 1'b1;
              state    <= fic_pkg::FIC_ST_CLEAR;
            end else begin
              state <= fic_pkg::FIC_ST_IDLE;
            end
          end
        end
        fic_pkg::FIC_ST_CLEAR: begin
          idx <= idx + 8'h01;
          if (clr_last) begin
            clr_auto <= 1'b0;
            state    <= fic_pkg::FIC_ST_IDLE;
          end
        end
        default: begin
          state <= fic_pkg::FIC_ST_IDLE;
        end
      endcase
    end
  end

  // Flash and buffer port steering
  always_comb begin
    fl_we    = 1'b0;
    fl_addr  = addr_full;
    fl_wdata = fic_pkg::WORD_ERASED;
    bf_we    = 1'b0;
    bf_addr  = addr_lo[BUF_W-1:0];
    bf_wdata = {bus_i.wdata, dlo[0]};
    case (state)
      fic_pkg::FIC_ST_IDLE: begin
        bf_we = PAGED && d0h_wr;
      end
      fic_pkg::FIC_ST_ERASE: begin
        fl_we   = 1'b1;
        fl_addr = {addr_full[ADDR_W-1:ERASE_W], idx[ERASE_W-1:0]};
      end
      fic_pkg::FIC_ST_PROG: begin
        bf_addr  = idx[BUF_W-1:0];
        fl_we    = phase;
        fl_addr  = {addr_full[ADDR_W-1:BUF_W], idx[BUF_W-1:0]};
        fl_wdata = PAGED ? bf_rdata : {dhi[idx[1:0]], dlo[idx[1:0]]};
      end
      fic_pkg::FIC_ST_CLEAR: begin
        bf_we    = 1'b1;
        bf_addr  = idx[BUF_W-1:0];
        bf_wdata = fic_pkg::WORD_ERASED;
      end
      default: begin
        fl_we = 1'b0;
      end
    endcase
  end

  // Program memory array
  fic_word_mem #(.DW(16), .AW(ADDR_W)) u_flash (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (fl_we),
    .addr_i  (fl_addr),
    .wdata_i (fl_wdata),
    .rdata_o (fl_rdata)
  );

  // Page write buffer
  fic_word_mem #(.DW(16), .AW(BUF_W)) u_wbuf (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (bf_we),
    .addr_i  (bf_addr),
    .wdata_i (bf_wdata),
    .rdata_o (bf_rdata)
  );

  // Read-back multiplexer
  always_comb begin
    rd_mux = 8'h00;
    case (bus_i.addr)
      fic_pkg::REG_CTRL:    rd_mux = {flag, mode, trig, pstart, rallow, rstart};
      fic_pkg::REG_CHIPRST: rd_mux = rst_pat;
      fic_pkg::REG_BUFCLR:  rd_mux = {7'h00, bclr};
      fic_pkg::REG_ADDR_L:  rd_mux = addr_lo;
      fic_pkg::REG_ADDR_H:  rd_mux = 8'(addr_hi);
      default: begin
        if (bus_i.addr >= fic_pkg::REG_DATA0_L && bus_i.addr <= fic_pkg::REG_DATA3_H) begin
          rd_mux = bus_i.addr[0] ? dlo[2'((bus_i.addr - fic_pkg::REG_DATA0_L) >> 1)]
                                 : dhi[2'((bus_i.addr - fic_pkg::REG_DATA0_L) >> 1)];
        end
      end
    endcase
  end

  // Registered read data and CPU stall
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o   <= 8'h00;
      cpu_stall_o <= 1'b0;
    end else if (ce_i) begin
      rd_data_o   <= bus_i.rd ? rd_mux : 8'h00;
      cpu_stall_o <= go_prog || go_erase || go_read || go_clear
                     || (!idle && !(read_done || (wait_end && !(after_prog && PAGED))
                     || clr_last));
    end
  end

endmodule

/* File: fic_iap_props.sv */
// Purpose: port-level assertions of the flash programming controller
// Assumes: ce_i held high, short erase and program counts
// Notes:   bound to every fic_iap_ctrl instance
module fic_iap_props #(
  parameter int ERASE_CYC = 4,
  parameter int PROG_CYC  = 4
) (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  ce_i,
  // Register port
  input wire fic_pkg::fic_bus_req_t bus_i,
  input wire logic [7:0]            rd_data_o,
  // System signals
  input wire logic                  cpu_stall_o,
  input wire logic                  chip_reset_o
);
  localparam int STALL_MAX = 300 + ERASE_CYC + PROG_CYC;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Accepted control writes
  wire ctrl_wr = bus_i.wr && bus_i.addr == fic_pkg::REG_CTRL && !cpu_stall_o;
  wire rd_cmd  = ctrl_wr && bus_i.wdata[6:0] == 7'h33;
  wire rst_wr  = bus_i.wr && bus_i.addr == fic_pkg::REG_CHIPRST && !cpu_stall_o
                 && bus_i.wdata == fic_pkg::CHIP_RST_CODE;

  property p_rd_idle;
    !$past(bus_i.rd) |-> rd_data_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_rd_start_clr;
    rd_cmd ##[4:40] (bus_i.rd && bus_i.addr == fic_pkg::REG_CTRL) |=> !rd_data_o[0];
  endproperty
  a_rd_start_clr: assert property (p_rd_start_clr) else $error("read start not cleared");
  property p_read_stall;
    rd_cmd |=> ##[0:1] cpu_stall_o [*2] ##1 !cpu_stall_o;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall length wrong");
  property p_refused;
    ctrl_wr && bus_i.wdata[6:4] == 3'h7 && bus_i.wdata[0] |=> !cpu_stall_o [*3];
  endproperty
  a_refused: assert property (p_refused) else $error("reserved mode started work");
  property p_stall_bound;
    $rose(cpu_stall_o) |-> ##[1:STALL_MAX] !cpu_stall_o;
  endproperty
  a_stall_bound: assert property (p_stall_bound) else $error("busy never ended");
  property p_chip_set;
    rst_wr |-> ##[1:2] chip_reset_o;
  endproperty
  a_chip_set: assert property (p_chip_set) else $error("chip reset missing");
  property p_chip_cause;
    $rose(chip_reset_o) |-> $past(rst_wr) || $past(rst_wr, 2);
  endproperty
  a_chip_cause: assert property (p_chip_cause) else $error("chip reset without cause");
  property p_chip_pulse;
    chip_reset_o && !rst_wr |=> !chip_reset_o;
  endproperty
  a_chip_pulse: assert property (p_chip_pulse) else $error("chip reset too long");
  // Main scenarios reached
  c_read: cover property (rd_cmd);
  c_busy: cover property ($rose(cpu_stall_o));
  c_chip: cover property ($rose(chip_reset_o));
endmodule

bind fic_iap_ctrl fic_iap_props #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) fic_iap_props_i (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .bus_i(bus_i),
  .rd_data_o(rd_data_o), .cpu_stall_o(cpu_stall_o), .chip_reset_o(chip_reset_o));

/* File: fic_pkg.sv */
// Purpose: shared constants and types of the flash programming controller
// Assumes: 10 MHz system clock, 8-bit register port
// Notes:   register indices are word-free 4-bit offsets on the register port
package fic_pkg;

  // Clock and operation timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned ENABLE_WIN_NS = 25600;
  localparam int unsigned ERASE_TIME_NS = 2000000;
  localparam int unsigned PROG_TIME_NS  = 2000000;
  localparam int unsigned ENABLE_CYC    = (ENABLE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CYC_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYC_DEF  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_CHIPRST = 4'h1;
  localparam logic [3:0] REG_BUFCLR  = 4'h2;
  localparam logic [3:0] REG_ADDR_L  = 4'h3;
  localparam logic [3:0] REG_ADDR_H  = 4'h4;
  localparam logic [3:0] REG_DATA0_L = 4'h5;
  localparam logic [3:0] REG_DATA3_H = 4'hc;

  // Control register fields
  localparam int CTRL_FLAG_BIT  = 7;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int CTRL_TRIG_BIT  = 3;
  localparam int CTRL_PSTART    = 2;
  localparam int CTRL_RALLOW    = 1;
  localparam int CTRL_RSTART    = 0;
  localparam int BUFCLR_BIT     = 0;

  // Operation select codes
  localparam logic [2:0] MODE_WRITE  = 3'h0;
  localparam logic [2:0] MODE_ERASE  = 3'h1;
  localparam logic [2:0] MODE_READ   = 3'h3;
  localparam logic [2:0] MODE_ENABLE = 3'h6;

  // Reset values and special patterns
  localparam logic [7:0]  REG_RST       = 8'h00;
  localparam logic [7:0]  CHIP_RST_CODE = 8'h55;
  localparam logic [15:0] WORD_ERASED   = 16'h0000;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } fic_bus_req_t;

  // Sequencer states
  typedef enum logic [5:0] {
    FIC_ST_IDLE  = 6'h01,
    FIC_ST_ERASE = 6'h02,
    FIC_ST_PROG  = 6'h04,
    FIC_ST_READ  = 6'h08,
    FIC_ST_CLEAR = 6'h10,
    FIC_ST_WAIT  = 6'h20
  } fic_state_t;

endpackage

/* File: fic_tb.sv */
// Purpose: self-checking bench of the flash programming controller
// Assumes: page variant of 64 words, short erase and program counts
// Notes:   CPU model drives the register port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] UNL [3] = '{16'h1a2b, 16'h3c4d, 16'h5e6f}; // Arbitrary values
  logic                  clk_i     = 1'b0;
  logic                  sys_rst_i = 1'b1;
  logic                  ce_i      = 1'b1;
  fic_pkg::fic_bus_req_t bus;
  logic [7:0]            rd_data;
  logic                  stall;
  logic                  chip_rst;
  logic                  seen_rst  = 1'b0;
  int                    error_cnt = 0;
  int                    checks    = 0;

  fic_iap_ctrl #(.VARIANT(2), .ERASE_CYC(4), .PROG_CYC(4), .UNLOCK_1(UNL[0]),
    .UNLOCK_2(UNL[1]), .UNLOCK_3(UNL[2])) fic_iap_ctrl_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .bus_i(bus),
    .rd_data_o(rd_data), .cpu_stall_o(stall), .chip_reset_o(chip_rst));
  fic_cpu_model fic_cpu_model_i (
    .clk_i(clk_i), .rd_data_i(rd_data), .stall_i(stall), .bus_o(bus));

  // Clock and sticky chip reset capture
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (chip_rst === 1'b1) seen_rst <= 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    fic_cpu_model_i.rd(a, d);
    check({8'h00, d}, {8'h00, e});
  endtask
  task automatic complete_run;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // All registers zero, unmapped index zero
  task automatic t_reset;
    for (int i = 0; i <= 12; i++) rdc(4'(i), 8'h00);
    rdc(4'hf, 8'h00);
  endtask
  // Enable mode with unlock patterns inside the window
  task automatic t_enable;
    fic_cpu_model_i.wr(4'h0, 8'h68);
    for (int i = 0; i < 3; i++) begin
      fic_cpu_model_i.wr(4'(7 + 2 * i), UNL[i][7:0]);
      fic_cpu_model_i.wr(4'(8 + 2 * i), UNL[i][15:8]);
    end
    repeat (300) @(posedge clk_i);
    rdc(4'h0, 8'he0);
  endtask
  // Page erase with nonzero offset, then blank read of another word
  task automatic t_erase;
    fic_cpu_model_i.wr(4'h3, 8'h25);
    fic_cpu_model_i.wr(4'h4, 8'h00);
    fic_cpu_model_i.cmd(4'h0, 8'h94);
    rdc(4'h0, 8'h90);
    fic_cpu_model_i.wr(4'h3, 8'h3e);
    fic_cpu_model_i.cmd(4'h0, 8'hb3);
    rdc(4'h0, 8'hb2);
    rdc(4'h5, 8'h00);
    rdc(4'h6, 8'h00);
  endtask
  // Buffer clear, load and address stepping up to the page end
  task automatic t_fill;
    fic_cpu_model_i.cmd(4'h2, 8'h01);
    rdc(4'h2, 8'h00);
    fic_cpu_model_i.wr(4'h3, 8'h3e);
    fic_cpu_model_i.wr(4'h5, 8'h11);
    rdc(4'h3, 8'h3e);
    fic_cpu_model_i.wr(4'h6, 8'h22);
    rdc(4'h3, 8'h3f);
    fic_cpu_model_i.wr(4'h6, 8'h33);
    rdc(4'h3, 8'h3f);
  endtask
  // Program the page and read both words back
  task automatic t_program;
    fic_cpu_model_i.cmd(4'h0, 8'h84);
    rdc(4'h0, 8'h80);
    for (int i = 0; i < 2; i++) begin
      fic_cpu_model_i.wr(4'h3, 8'(8'h3e + i));
      fic_cpu_model_i.cmd(4'h0, 8'hb3);
      rdc(4'h5, 8'h11);
      rdc(4'h6, (i == 0) ? 8'h22 : 8'h33);
    end
  endtask
  // Refused commands and flag handling
  task automatic t_refuse;
    fic_cpu_model_i.cmd(4'h0, 8'hf1);
    rdc(4'h0, 8'hf0);
    fic_cpu_model_i.cmd(4'h0, 8'hb1);
    rdc(4'h0, 8'hb0);
    fic_cpu_model_i.wr(4'h0, 8'h00);
    rdc(4'h0, 8'h00);
    fic_cpu_model_i.wr(4'h0, 8'h80);
    rdc(4'h0, 8'h00);
    fic_cpu_model_i.cmd(4'h0, 8'h14);
    rdc(4'h0, 8'h10);
    fic_cpu_model_i.wr(4'h5, 8'haa);
    rdc(4'h5, 8'h11);
  endtask
  // Chip reset pattern
  task automatic t_chip;
    fic_cpu_model_i.wr(4'h1, 8'h55);
    repeat (3) @(posedge clk_i);
    #1;
    check({15'h0000, seen_rst}, 16'h0001);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_enable();
    t_erase();
    t_fill();
    t_program();
    t_refuse();
    t_chip();
    complete_run();
  end
  // Watchdog
  initial begin
    #3000000;
    error_cnt++;
    complete_run();
  end
endmodule

/* File: fic_word_mem.sv */
// Purpose: single-port word memory with registered read data
// Assumes: one access per cycle, write has priority over read
// Notes:   used for the flash array and for the page write buffer
module fic_word_mem #(
  parameter int DW = 16,
  parameter int AW = 6
) (
  // Clock and enable
  input  wire logic          clk_i,
  input  wire logic          ce_i,
  // Access port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [2**AW];

  // Write, or registered read
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end else begin
        rdata_o <= mem[addr_i];
      end
    end
  end

endmodule
